//--- common/uart_pkg.sv
// Shared register map, field layout, reset values and state codes
package uart_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_RXSTAT = 12'h004;
  localparam logic [11:0] OFS_FLAG = 12'h018;
  localparam logic [11:0] OFS_IDIV = 12'h024;
  localparam logic [11:0] OFS_FDIV = 12'h028;
  localparam logic [11:0] OFS_LINE = 12'h02C;
  localparam logic [11:0] OFS_CTRL = 12'h030;
  localparam logic [11:0] OFS_LEVEL = 12'h034;
  localparam logic [11:0] OFS_MASK = 12'h038;
  localparam logic [11:0] OFS_RAW = 12'h03C;
  localparam logic [11:0] OFS_MSTAT = 12'h040;
  localparam logic [11:0] OFS_CLEAR = 12'h044;
  // Line control fields
  localparam int LC_BRK = 0;
  localparam int LC_PEN = 1;
  localparam int LC_EVEN = 2;
  localparam int LC_STOP2 = 3;
  localparam int LC_FIFO = 4;
  localparam int LC_WLEN = 5;
  localparam int LC_STICK = 7;
  // Control fields and reset value
  localparam int CT_EN = 0;
  localparam int CT_LOOP = 7;
  localparam int CT_TX = 8;
  localparam int CT_RX = 9;
  localparam logic [9:0] CTRL_RESET = 10'h300;
  localparam logic [5:0] LEVEL_RESET = 6'h12;
  // Event bits
  localparam int EV_RX = 4;
  localparam int EV_TX = 5;
  localparam int EV_RTO = 6;
  localparam int EV_FRM = 7;
  localparam int EV_PAR = 8;
  localparam int EV_BRK = 9;
  localparam int EV_OVR = 10;
  // Status nibble of a receive entry, above the data byte
  localparam int ST_FRM = 0;
  localparam int ST_PAR = 1;
  localparam int ST_BRK = 2;
  localparam int ST_OVR = 3;
  // Flag bits
  localparam int FL_BUSY = 3;
  localparam int FL_RXE = 4;
  localparam int FL_TXF = 5;
  localparam int FL_RXF = 6;
  localparam int FL_TXE = 7;
  // Oversampling counts
  localparam logic [3:0] BIT_END = 4'hF;
  localparam logic [3:0] START_TICK = 4'h7;
  localparam logic [9:0] TMO_TICKS = 10'h200;
  // Transmit and receive states
  typedef enum logic [4:0] {TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
    TX_PAR = 5'h08, TX_STOP = 5'h10} tx_state_t;
  typedef enum logic [5:0] {RX_IDLE = 6'h01, RX_START = 6'h02, RX_DATA = 6'h04,
    RX_PAR = 6'h08, RX_STOP = 6'h10, RX_BRK = 6'h20} rx_state_t;
  // Trigger level in entries for a level code
  function automatic logic [4:0] lvl_of(input logic [2:0] code);
    case (code)
      3'h0: lvl_of = 5'h02;
      3'h1: lvl_of = 5'h04;
      3'h3: lvl_of = 5'h0C;
      3'h4: lvl_of = 5'h0E;
      default: lvl_of = 5'h08;
    endcase
  endfunction
endpackage

//--- common/fifo_if.sv
// Queue port between the top and a FIFO store
`timescale 1ns/100ps
interface fifo_if #(parameter int W = 8, parameter int CW = 5);
  logic push;
  logic pop;
  logic one_deep;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic [CW-1:0] count;
  logic full;
  logic empty;
  modport user (output push, pop, one_deep, wdata, input rdata, count, full, empty);
  modport store (input push, pop, one_deep, wdata, output rdata, count, full, empty);
endinterface

//--- rtl/sync_fifo.sv
// FIFO store with a single-entry holding mode
`timescale 1ns/100ps
module sync_fifo #(parameter int W = 8, parameter int DEPTH = 16) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Store side of the queue
  fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  // Whole queue state
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem_reg;
    logic [AW-1:0] rd_reg;
    logic [AW-1:0] wr_reg;
    logic [AW:0] cnt_reg;
  } fifo_state_t;
  fifo_state_t st_reg, st_next;
  logic [AW:0] limit;
  logic do_push;
  logic do_pop;
  // Holding mode caps the queue at one entry
  assign limit = f.one_deep ? (AW+1)'(1) : (AW+1)'(DEPTH);
  assign f.full = st_reg.cnt_reg >= limit;
  assign f.empty = st_reg.cnt_reg == '0;
  assign f.count = st_reg.cnt_reg;
  assign f.rdata = st_reg.mem_reg[st_reg.rd_reg];
  assign do_push = f.push && !f.full;
  assign do_pop = f.pop && !f.empty;
  // Pointer and count update
  always_comb begin
    st_next = st_reg;
    if (do_push) begin
      st_next.mem_reg[st_reg.wr_reg] = f.wdata;
      st_next.wr_reg = st_reg.wr_reg + 1'b1;
    end
    if (do_pop) begin
      st_next.rd_reg = st_reg.rd_reg + 1'b1;
    end
    st_next.cnt_reg = st_reg.cnt_reg + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
  end
  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  fifo_bound_a: assert property (do_push && !do_pop |=> f.count == $past(f.count) + 1'b1)
    else $error("fifo count did not grow on push");
endmodule

//--- rtl/baud_gen.sv
// Fractional oversampling tick generator
`timescale 1ns/100ps
module baud_gen (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Divisor
  input wire logic [15:0] idiv,
  input wire logic [5:0] fdiv,
  // Oversample tick
  output logic tick
);
  // Counter, fraction accumulator, pending extra cycle
  typedef struct packed {
    logic [15:0] cnt_reg;
    logic [5:0] acc_reg;
    logic ext_reg;
    logic tick_reg;
  } baud_state_t;
  baud_state_t st_reg, st_next;
  logic [16:0] last;
  logic [6:0] sum;
  // Period is the integer part plus one when the fraction overflowed
  assign last = {1'b0, idiv} + {16'h0, st_reg.ext_reg} - 17'h1;
  assign sum = {1'b0, st_reg.acc_reg} + {1'b0, fdiv};
  assign tick = st_reg.tick_reg;
  always_comb begin
    st_next = st_reg;
    st_next.tick_reg = 1'b0;
    if (idiv == 16'h0) begin
      // Stopped while no divisor is set
      st_next.cnt_reg = 16'h0;
    end else if ({1'b0, st_reg.cnt_reg} >= last) begin
      // End of one oversample period
      st_next.cnt_reg = 16'h0;
      st_next.tick_reg = 1'b1;
      {st_next.ext_reg, st_next.acc_reg} = sum;
    end else begin
      st_next.cnt_reg = st_reg.cnt_reg + 16'h1;
    end
  end
  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  tick_gap_a: assert property (tick && idiv > 16'h1 |=> !tick)
    else $error("oversample ticks too close");
endmodule

//--- rtl/uart_top.sv
// Serial port with APB registers, FIFOs and line logic
`timescale 1ns/100ps
module uart_top import uart_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic serial_in,
  output logic serial_out,
  // Interrupt request
  output logic uart_irq
);
  ////////////////////////////////////////////////////////////////////
  // All state of the block outside the queues and the baud generator
  typedef struct packed {
    logic [15:0] idiv_reg;
    logic [5:0] fdiv_reg;
    logic [7:0] line_reg;
    logic [29:0] act_reg;
    logic [9:0] ctrl_reg;
    logic [5:0] level_reg;
    logic [10:0] mask_reg;
    logic [10:0] raw_reg;
    logic [3:0] rstat_reg;
    logic [31:0] rdata_reg;
    logic perr_reg;
    logic [2:0] sync_reg;
    logic rxl_reg;
    tx_state_t txs_reg;
    logic [3:0] txc_reg;
    logic [2:0] txb_reg;
    logic [7:0] txd_reg;
    logic tx2_reg;
    logic out_reg;
    logic pin_reg;
    rx_state_t rxs_reg;
    logic [3:0] rxc_reg;
    logic [2:0] rxb_reg;
    logic [7:0] rxd_reg;
    logic rxp_reg;
    logic rxz_reg;
    logic ovp_reg;
    logic [9:0] tmo_reg;
    logic rxq_reg;
    logic txq_reg;
    logic irq_reg;
  } state_t;
  state_t st_reg, st_next;
  ////////////////////////////////////////////////////////////////////
  // Decoded settings
  logic tick; // Oversample tick
  logic en, transmit_enable_bit, receive_enable_bit, loop, fifo_enable_bit, pen, even, stick, two;
  logic [1:0] wl; // Word length code
  logic [2:0] last; // Index of the last data bit
  logic [7:0] wmask; // Active data bits
  logic par_tx, par_rx; // Parity bit to send and to expect
  logic rx_in; // Receive line after loopback select
  logic busy;
  logic setup, wr, rd; // APB phases
  logic [10:0] ev_set, ev_clr;
  logic [31:0] rd_val;
  logic [7:0] flags;
  logic txf_push, txf_pop, rxf_push, rxf_pop;
  logic [11:0] rxf_wdata;
  logic rx_cond, tx_cond, brk, o;
  assign en = st_reg.ctrl_reg[CT_EN];
  assign transmit_enable_bit = st_reg.ctrl_reg[CT_TX];
  assign receive_enable_bit = st_reg.ctrl_reg[CT_RX];
  assign loop = st_reg.ctrl_reg[CT_LOOP];
  // Format comes from the loaded copy only
  assign pen = st_reg.act_reg[LC_PEN];
  assign even = st_reg.act_reg[LC_EVEN];
  assign stick = st_reg.act_reg[LC_STICK];
  assign two = st_reg.act_reg[LC_STOP2];
  assign fifo_enable_bit = st_reg.act_reg[LC_FIFO];
  assign wl = st_reg.act_reg[LC_WLEN+:2];
  assign last = 3'h4 + {1'b0, wl};
  assign wmask = 8'hFF >> (2'h3 - wl);
  // Stick parity sends the inverse of the even bit
  assign par_tx = stick ? ~even : ~((^(st_reg.txd_reg & wmask)) ^ even);
  assign par_rx = stick ? ~even : ~((^(st_reg.rxd_reg & wmask)) ^ even);
  assign rx_in = loop ? st_reg.out_reg : st_reg.rxl_reg;
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  ////////////////////////////////////////////////////////////////////
  // Baud generator and queues
  fifo_if #(.W(8)) txf();
  fifo_if #(.W(12)) rxf();
  baud_gen u_baud (.clock(clock), .sys_rst(sys_rst), .idiv(st_reg.act_reg[29:14]),
    .fdiv(st_reg.act_reg[13:8]), .tick(tick));
  sync_fifo #(.W(8)) u_txq (.clock(clock), .sys_rst(sys_rst), .f(txf.store));
  sync_fifo #(.W(12)) u_rxq (.clock(clock), .sys_rst(sys_rst), .f(rxf.store));
  assign txf.push = txf_push;
  assign txf.pop = txf_pop;
  assign txf.wdata = pwdata[7:0];
  assign txf.one_deep = !fifo_enable_bit;
  assign rxf.push = rxf_push;
  assign rxf.pop = rxf_pop;
  assign rxf.wdata = rxf_wdata;
  assign rxf.one_deep = !fifo_enable_bit;
  // Busy covers both queued and shifting characters
  assign busy = !txf.empty || st_reg.txs_reg != TX_IDLE;
  // Level conditions for the queue events
  assign rx_cond = fifo_enable_bit ? rxf.count >= lvl_of(st_reg.level_reg[5:3]) : !rxf.empty;
  assign tx_cond = fifo_enable_bit ? txf.count <= lvl_of(st_reg.level_reg[2:0]) : txf.empty;
  assign brk = st_reg.rxz_reg && !rx_in;
  ////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    txf_push = 1'b0;
    txf_pop = 1'b0;
    rxf_push = 1'b0;
    rxf_pop = 1'b0;
    rxf_wdata = 12'h000;
    ev_set = 11'h000;
    ev_clr = 11'h000;
    rd_val = 32'h0000_0000;
    o = 1'b1;
    // Flag word
    flags = 8'h00;
    flags[FL_BUSY] = busy;
    flags[FL_RXE] = rxf.empty;
    flags[FL_TXF] = txf.full;
    flags[FL_RXF] = rxf.full;
    flags[FL_TXE] = txf.empty;
    // Receive pin synchroniser and agreement filter
    st_next.sync_reg = {st_reg.sync_reg[1:0], serial_in};
    if (st_reg.sync_reg[1] == st_reg.sync_reg[2]) begin
      st_next.rxl_reg = st_reg.sync_reg[2];
    end
    // Read data captured in the setup cycle
    if (setup) begin
      st_next.perr_reg = 1'b0;
      case (paddr)
        OFS_DATA: rd_val = {20'h0, rxf.rdata};
        OFS_RXSTAT: rd_val = {28'h0, st_reg.rstat_reg};
        OFS_FLAG: rd_val = {24'h0, flags};
        OFS_IDIV: rd_val = {16'h0, st_reg.idiv_reg};
        OFS_FDIV: rd_val = {26'h0, st_reg.fdiv_reg};
        OFS_LINE: rd_val = {24'h0, st_reg.line_reg};
        OFS_CTRL: rd_val = {22'h0, st_reg.ctrl_reg};
        OFS_LEVEL: rd_val = {26'h0, st_reg.level_reg};
        OFS_MASK: rd_val = {21'h0, st_reg.mask_reg};
        OFS_RAW: rd_val = {21'h0, st_reg.raw_reg};
        OFS_MSTAT: rd_val = {21'h0, st_reg.raw_reg & st_reg.mask_reg};
        OFS_CLEAR: rd_val = 32'h0000_0000;
        default: st_next.perr_reg = 1'b1;
      endcase
      st_next.rdata_reg = rd_val;
    end
    // Register writes in the access cycle
    if (wr) begin
      case (paddr)
        OFS_DATA: txf_push = 1'b1;
        OFS_RXSTAT: st_next.rstat_reg = 4'h0;
        OFS_IDIV: st_next.idiv_reg = pwdata[15:0];
        OFS_FDIV: st_next.fdiv_reg = pwdata[5:0];
        OFS_LINE: begin
          // Divisor and format take effect together
          st_next.line_reg = pwdata[7:0];
          st_next.act_reg = {st_reg.idiv_reg, st_reg.fdiv_reg, pwdata[7:0]};
        end
        OFS_CTRL: st_next.ctrl_reg = pwdata[9:0];
        OFS_LEVEL: st_next.level_reg = pwdata[5:0];
        OFS_MASK: st_next.mask_reg = pwdata[10:0];
        OFS_CLEAR: ev_clr = pwdata[10:0];
        default: ev_clr = 11'h000;
      endcase
    end
    // Data read pops the head and keeps its status
    if (rd && paddr == OFS_DATA && !rxf.empty) begin
      rxf_pop = 1'b1;
      st_next.rstat_reg = rxf.rdata[11:8];
      // Reading the queue empty ends a timeout
      ev_clr[EV_RTO] = rxf.count == 5'h01;
    end
    ////////////////////////////////////////////////////////////////
    // Transmitter
    case (st_reg.txs_reg)
      TX_IDLE: begin
        // A new character starts only while enabled
        if (!txf.empty && en && transmit_enable_bit) begin
          txf_pop = 1'b1;
          st_next.txd_reg = txf.rdata;
          st_next.txs_reg = TX_START;
          st_next.txc_reg = 4'h0;
          st_next.tx2_reg = 1'b0;
        end
      end
      default: begin
        // Sixteen ticks per bit
        if (tick) begin
          st_next.txc_reg = st_reg.txc_reg + 4'h1;
          if (st_reg.txc_reg == BIT_END) begin
            case (st_reg.txs_reg)
              TX_START: begin
                st_next.txs_reg = TX_DATA;
                st_next.txb_reg = 3'h0;
              end
              TX_DATA: begin
                if (st_reg.txb_reg == last) begin
                  st_next.txs_reg = pen ? TX_PAR : TX_STOP;
                end else begin
                  st_next.txb_reg = st_reg.txb_reg + 3'h1;
                end
              end
              TX_PAR: st_next.txs_reg = TX_STOP;
              default: begin
                // Optional second stop bit
                if (two && !st_reg.tx2_reg) begin
                  st_next.tx2_reg = 1'b1;
                end else begin
                  st_next.txs_reg = TX_IDLE;
                end
              end
            endcase
          end
        end
      end
    endcase
    // Line level for the next state
    case (st_next.txs_reg)
      TX_START: o = 1'b0;
      TX_DATA: o = st_next.txd_reg[st_next.txb_reg];
      TX_PAR: o = par_tx;
      default: o = 1'b1;
    endcase
    st_next.out_reg = o && !st_reg.act_reg[LC_BRK];
    // Pin stays idle in loopback
    st_next.pin_reg = st_next.out_reg || loop;
    ////////////////////////////////////////////////////////////////
    // Receiver
    case (st_reg.rxs_reg)
      RX_IDLE: begin
        // Low level on the line in idle starts a character
        if (en && receive_enable_bit && !rx_in) begin
          st_next.rxs_reg = RX_START;
          st_next.rxc_reg = 4'h0;
          st_next.rxd_reg = 8'h00;
          st_next.rxz_reg = 1'b1;
          st_next.rxp_reg = 1'b0;
        end
      end
      RX_BRK: begin
        // Wait for marking state after a break
        if (rx_in) begin
          st_next.rxs_reg = RX_IDLE;
        end
      end
      default: begin
        if (tick) begin
          st_next.rxc_reg = st_reg.rxc_reg + 4'h1;
          if (st_reg.rxs_reg == RX_START) begin
            // Start must still be low on the eighth tick
            if (st_reg.rxc_reg == START_TICK) begin
              st_next.rxc_reg = 4'h0;
              st_next.rxb_reg = 3'h0;
              st_next.rxs_reg = rx_in ? RX_IDLE : RX_DATA;
            end
          end else if (st_reg.rxc_reg == BIT_END) begin
            st_next.rxz_reg = st_reg.rxz_reg && !rx_in;
            case (st_reg.rxs_reg)
              RX_DATA: begin
                st_next.rxd_reg[st_reg.rxb_reg] = rx_in;
                if (st_reg.rxb_reg == last) begin
                  st_next.rxs_reg = pen ? RX_PAR : RX_STOP;
                end else begin
                  st_next.rxb_reg = st_reg.rxb_reg + 3'h1;
                end
              end
              RX_PAR: begin
                st_next.rxp_reg = rx_in != par_rx;
                st_next.rxs_reg = RX_STOP;
              end
              default: begin
                // Stop sample ends the character
                st_next.rxs_reg = brk ? RX_BRK : RX_IDLE;
                if (rxf.full) begin
                  // Character lost, next one carries the mark
                  ev_set[EV_OVR] = 1'b1;
                  st_next.ovp_reg = 1'b1;
                  st_next.rstat_reg[ST_OVR] = 1'b1;
                end else begin
                  rxf_push = 1'b1;
                  rxf_wdata = {st_reg.ovp_reg, brk, st_reg.rxp_reg, !rx_in,
                    brk ? 8'h00 : st_reg.rxd_reg};
                  st_next.ovp_reg = 1'b0;
                  ev_set[EV_FRM] = !rx_in;
                  ev_set[EV_PAR] = st_reg.rxp_reg;
                  ev_set[EV_BRK] = brk;
                end
              end
            endcase
          end
        end
      end
    endcase
    ////////////////////////////////////////////////////////////////
    // Receive timeout counter
    if (rxf.empty || rxf_push || rxf_pop) begin
      st_next.tmo_reg = 10'h000;
    end else if (tick && st_reg.tmo_reg != TMO_TICKS) begin
      st_next.tmo_reg = st_reg.tmo_reg + 10'h001;
      ev_set[EV_RTO] = st_reg.tmo_reg == TMO_TICKS - 10'h001;
    end
    // Level events on entry into the condition
    st_next.rxq_reg = rx_cond;
    st_next.txq_reg = tx_cond;
    ev_set[EV_RX] = rx_cond && !st_reg.rxq_reg;
    ev_set[EV_TX] = tx_cond && !st_reg.txq_reg;
    // A new event wins over a clear in the same cycle
    st_next.raw_reg = (st_reg.raw_reg & ~ev_clr) | ev_set;
    st_next.irq_reg = |(st_next.raw_reg & st_next.mask_reg);
  end
  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.ctrl_reg <= CTRL_RESET;
      st_reg.level_reg <= LEVEL_RESET;
      st_reg.txs_reg <= TX_IDLE;
      st_reg.rxs_reg <= RX_IDLE;
      st_reg.sync_reg <= 3'h7;
      st_reg.rxl_reg <= 1'b1;
      st_reg.out_reg <= 1'b1;
      st_reg.pin_reg <= 1'b1;
      st_reg.txq_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  // Outputs
  assign prdata = st_reg.rdata_reg;
  assign pslverr = st_reg.perr_reg;
  assign pready = 1'b1;
  assign serial_out = st_reg.pin_reg;
  assign uart_irq = st_reg.irq_reg;
  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  busy_hold_a: assert property (st_reg.txs_reg != TX_IDLE |-> flags[FL_BUSY])
    else $error("busy low while shifting");
  false_start_a: assert property (st_reg.rxs_reg == RX_START && tick
    && st_reg.rxc_reg == START_TICK && rx_in |=> st_reg.rxs_reg == RX_IDLE)
    else $error("false start not ignored");
  divisor_load_a: assert property ($changed(st_reg.act_reg) |->
    $past(wr) && $past(paddr) == OFS_LINE)
    else $error("divisor changed without line write");
  start_low_a: assert property (st_reg.txs_reg == TX_START && !loop |-> !serial_out)
    else $error("start bit not low");
  event_clear_a: assert property (wr && paddr == OFS_CLEAR && pwdata[EV_PAR]
    && !ev_set[EV_PAR] |=> !st_reg.raw_reg[EV_PAR])
    else $error("parity event not cleared");
  mask_gate_a: assert property ((st_reg.raw_reg & st_reg.mask_reg) == 11'h000
    && !$past(ev_set[EV_OVR]) |-> !uart_irq)
    else $error("request with nothing enabled");
endmodule

//--- test/serial_peer.sv
// Remote serial peer that sends and receives 8N1 frames
`timescale 1ns/100ps
module serial_peer #(parameter int BIT = 16) (
  // Clock and lines
  input wire logic clock,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] got; // Last byte heard
  initial line_out = 1'b1; // Idle high
  // Start, data LSB first, stop at the given level
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (BIT) @(posedge clock);
    end
    line_out <= 1'b1;
  endtask
  // Receiver: sample each data bit mid period
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clock);
      got[i] = line_in;
    end
    repeat (BIT) @(posedge clock);
  end
endmodule

//--- test/tb_top.sv
// Register level bench for the serial port
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module tb_top import uart_pkg::*;;
  logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, serial_in, serial_out, uart_irq, se;
  int err_count = 0, n_compared = 0;
  always #20 clock = ~clock; // 25 MHz
  uart_top dut (.clock(clock), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in(serial_in),
    .serial_out(serial_out), .uart_irq(uart_irq));
  // Divisor 1 gives sixteen clocks a bit
  serial_peer #(.BIT(16)) peer (.clock(clock), .line_in(serial_out), .line_out(serial_in));
  // Verdict and end of run
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One APB transfer: setup, then access until pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge clock);
    penable <= 1;
    n = 0;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata; se = pslverr;
    psel <= 0; penable <= 0;
    if (n >= 50) begin err_count++; close_out(); end
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
    xfer(0, a, 0);
    `CHK(rd, e)
  endtask
  // Poll a flag bit until it has the wanted level
  task automatic wait_flag(input int b, input logic v);
    int n;
    n = 0;
    do begin xfer(0, OFS_FLAG, 0); n++; end while (rd[b] !== v && n < 400);
    if (n >= 400) begin err_count++; close_out(); end
  endtask
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 0;
    chk_rd(OFS_CTRL, 32'h00000300);
    chk_rd(OFS_LEVEL, 32'h00000012);
    chk_rd(OFS_FLAG, 32'h00000090);
    xfer(0, 12'h008, 0);
    `CHK(se, 1'b1)
    xfer(1, OFS_IDIV, 32'h00000001);
    xfer(1, OFS_LINE, 32'h00000070);
    // Only the framing event may reach the request line
    xfer(1, OFS_MASK, 32'h00000080);
    xfer(1, OFS_CTRL, 32'h00000301);
    xfer(1, OFS_DATA, 32'h0000003C);
    xfer(0, OFS_FLAG, 0);
    `CHK(rd[FL_BUSY], 1'b1)
    wait_flag(FL_BUSY, 1'b0);
    `CHK(peer.got, 8'h3C)
    peer.send(8'h5A, 1'b1);
    wait_flag(FL_RXE, 1'b0);
    chk_rd(OFS_DATA, 32'h0000005A);
    peer.send(8'h81, 1'b0);
    wait_flag(FL_RXE, 1'b0);
    chk_rd(OFS_DATA, 32'h00000181);
    chk_rd(OFS_RXSTAT, 32'h00000001);
    `CHK(uart_irq, 1'b1)
    chk_rd(OFS_MSTAT, 32'h00000080);
    // Clear every event, parity included
    xfer(1, OFS_CLEAR, 32'h000007F0);
    chk_rd(OFS_RAW, 32'h00000000);
    `CHK(uart_irq, 1'b0)
    // Disable before the control word is changed
    xfer(1, OFS_CTRL, 32'h00000300);
    xfer(1, OFS_CTRL, 32'h00000381);
    xfer(1, OFS_DATA, 32'h000000A5);
    wait_flag(FL_RXE, 1'b0);
    chk_rd(OFS_DATA, 32'h000000A5);
    close_out();
  end
endmodule
